// [verilog/hma_mode_arbiter.sv]
// Operating mode arbiter of a room temperature controller, with AXI4-Lite registers.
// Functional notes
// - Every mode change updates the comfort, standby, night and frost status objects, readable when reading is on.
// - With transmit on, each changed status object is sent without being asked.
// - After reset or initialisation the status object of the current mode is refreshed and sent.
// - With the presence button, the presence object is one exactly while a comfort extension runs.
// - The presence object drops when the extension expires or a higher source changes the mode.
// - Any value arriving on a mode object resets the presence button status.
// - One byte change-over value sets the mode as soon as it arrives.
// - Forced value 01 gives comfort, 02 standby, over every other source; 00 forces nothing.
// - Without forcing, an open window selects frost/heat protection.
// - Otherwise change-over 01..04 map to comfort, standby, night and frost.
// - Change-over 00 leaves the mode as it was.
// - Presence button active gives comfort for 01 or 02 and comfort extension for 03 or 04.
// - Motion active gives comfort whatever the change-over value.
// - Window one means open, zero closed; on closing the earlier mode returns.
// - When motion ends, the mode before presence returns, including change-overs received meanwhile.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
module hma_mode_arbiter
   import hma_pkg::*;
#(
   parameter int TICK_CYC = hma_pkg::EXT_TICK_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Object transmit
   output logic tx_valid,
   output logic [1:0] tx_obj,
   output logic tx_val,
   // Object state
   output logic [3:0] status_obj,
   output logic presence_obj,
   output logic [2:0] op_mode
);
   import hma_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic awh;
      logic wh;
      logic [7:0] awa;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic awrdy;
      logic wrdy;
      logic bv;
      logic [1:0] bresp;
      logic arrdy;
      logic rv;
      logic [31:0] rdat;
      logic [1:0] rresp;
      logic motion_cfg;
      logic tx_en;
      logic rd_en;
      logic init;
      logic [15:0] extlen;
      logic [7:0] chg;
      logic [7:0] frc;
      logic win;
      logic btn;
      logic mot;
      hma_mode_e base;
      hma_mode_e mode;
      logic [3:0] stat;
      logic [3:0] pend;
      logic txv;
      logic [1:0] txo;
      logic txval;
      logic pres;
      logic [27:0] div;
      logic tick;
      logic start;
      logic abort;
   } hma_state_s;

   hma_state_s s_q;
   hma_state_s s_d;
   hma_ext_if ext ();

   logic wr_chg;
   logic wr_frc;
   logic wr_pres;
   logic no_force;
   logic [1:0] idx;
   logic [3:0] sent;

   hma_ext_timer u_timer (
      .mclk(mclk),
      .rstn(rstn),
      .ext(ext)
   );

   assign ext.tick = s_q.tick;
   assign ext.start = s_q.start;
   assign ext.abort = s_q.abort;
   assign ext.len = s_q.extlen;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      wr_chg = 1'b0;
      wr_frc = 1'b0;
      wr_pres = 1'b0;
      idx = 2'h0;
      sent = 4'h0;
      s_d.txv = 1'b0;
      s_d.init = 1'b0;
      s_d.tick = 1'b0;
      s_d.start = 1'b0;
      s_d.abort = 1'b0;
      no_force = s_q.frc != FRC_COMFORT && s_q.frc != FRC_STANDBY;

      // Extension time base: one tick per divider period.
      if (s_q.div == 28'(TICK_CYC - 1)) begin
         s_d.div = 28'h0000000;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 28'h0000001;
      end

      // Priority is resolved from registered objects, so a telegram acts one cycle later.
      if (s_q.frc == FRC_COMFORT) begin
         s_d.mode = HMA_COMFORT;
      end else if (s_q.frc == FRC_STANDBY) begin
         s_d.mode = HMA_STANDBY;
      end else if (s_q.win) begin
         s_d.mode = HMA_FROST;
      end else if (s_q.motion_cfg && s_q.mot) begin
         s_d.mode = HMA_COMFORT;
      end else if (!s_q.motion_cfg && s_q.btn) begin
         if (s_q.base == HMA_COMFORT || s_q.base == HMA_STANDBY) begin
            s_d.mode = HMA_COMFORT;
         end else if (s_q.extlen != 16'h0000) begin
            s_d.mode = HMA_EXT;
         end else begin
            s_d.mode = s_q.base;
         end
      end else begin
         // Base mode keeps the change-overs taken meanwhile, so it returns here.
         s_d.mode = s_q.base;
      end

      // The extension ends whenever a higher source takes over; the button is dropped then.
      s_d.start = s_d.mode == HMA_EXT && s_q.mode != HMA_EXT;
      s_d.abort = s_d.mode != HMA_EXT && s_q.mode == HMA_EXT;
      if (s_d.abort || ext.expired) begin
         s_d.btn = 1'b0;
      end

      // Write channels are taken in either order and joined here.
      if (s_axi_awvalid && s_q.awrdy) begin
         s_d.awh = 1'b1;
         s_d.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wrdy) begin
         s_d.wh = 1'b1;
         s_d.wdat = s_axi_wdata;
         s_d.wstb = s_axi_wstrb;
      end
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end
      if (s_q.awh && s_q.wh) begin
         s_d.awh = 1'b0;
         s_d.wh = 1'b0;
         s_d.bv = 1'b1;
         s_d.bresp = RESP_OKAY;
         unique case (s_q.awa)
            ADDR_CTRL: begin
               if (s_q.wstb[0]) begin
                  s_d.motion_cfg = s_q.wdat[CTRL_MOTION_BIT];
                  s_d.tx_en = s_q.wdat[CTRL_TXEN_BIT];
                  s_d.rd_en = s_q.wdat[CTRL_RDEN_BIT];
                  s_d.init = s_q.wdat[CTRL_INIT_BIT];
               end
            end
            ADDR_CHG: begin
               if (s_q.wstb[0]) begin
                  wr_chg = 1'b1;
                  s_d.chg = s_q.wdat[7:0];
                  s_d.btn = 1'b0;
                  unique case (s_q.wdat[7:0])
                     CO_COMFORT: s_d.base = HMA_COMFORT;
                     CO_STANDBY: s_d.base = HMA_STANDBY;
                     CO_NIGHT: s_d.base = HMA_NIGHT;
                     CO_FROST: s_d.base = HMA_FROST;
                     default: s_d.base = s_q.base;
                  endcase
               end
            end
            ADDR_FRC: begin
               if (s_q.wstb[0]) begin
                  wr_frc = 1'b1;
                  s_d.frc = s_q.wdat[7:0];
                  s_d.btn = 1'b0;
               end
            end
            ADDR_WIN: begin
               if (s_q.wstb[0]) begin
                  s_d.win = s_q.wdat[0];
               end
            end
            ADDR_PRES: begin
               if (s_q.wstb[0]) begin
                  wr_pres = 1'b1;
                  if (s_q.motion_cfg) begin
                     s_d.mot = s_q.wdat[0];
                  end else begin
                     s_d.btn = s_q.wdat[0];
                  end
               end
            end
            ADDR_EXTLEN: begin
               if (s_q.wstb[0]) begin
                  s_d.extlen[7:0] = s_q.wdat[7:0];
               end
               if (s_q.wstb[1]) begin
                  s_d.extlen[15:8] = s_q.wdat[15:8];
               end
            end
            ADDR_STAT: begin
               s_d.bresp = RESP_OKAY;
            end
            default: begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Read channel.
      if (s_axi_arvalid && s_q.arrdy) begin
         s_d.rv = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdat = 32'h00000000;
         unique case (s_axi_araddr)
            ADDR_CTRL: begin
               s_d.rdat[CTRL_MOTION_BIT] = s_q.motion_cfg;
               s_d.rdat[CTRL_TXEN_BIT] = s_q.tx_en;
               s_d.rdat[CTRL_RDEN_BIT] = s_q.rd_en;
            end
            ADDR_CHG: s_d.rdat[7:0] = s_q.chg;
            ADDR_FRC: s_d.rdat[7:0] = s_q.frc;
            ADDR_WIN: s_d.rdat[0] = s_q.win;
            ADDR_PRES: s_d.rdat[0] = s_q.pres;
            ADDR_EXTLEN: s_d.rdat[15:0] = s_q.extlen;
            ADDR_STAT: begin
               s_d.rdat[2:0] = s_q.mode;
               // Status objects read as zero while reading is not permitted.
               s_d.rdat[STAT_OBJ_LSB +: 4] = s_q.rd_en ? s_q.stat : 4'h0;
               s_d.rdat[STAT_PRES_BIT] = s_q.pres;
               s_d.rdat[STAT_RUN_BIT] = ext.running;
            end
            default: s_d.rresp = RESP_SLVERR;
         endcase
      end else if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end
      s_d.awrdy = !s_d.awh && !s_d.bv;
      s_d.wrdy = !s_d.wh && !s_d.bv;
      s_d.arrdy = !s_d.rv;

      // Status objects follow the registered mode.
      s_d.stat = 4'h0;
      s_d.stat[OBJ_COMFORT] = s_q.mode == HMA_COMFORT || s_q.mode == HMA_EXT;
      s_d.stat[OBJ_STANDBY] = s_q.mode == HMA_STANDBY;
      s_d.stat[OBJ_NIGHT] = s_q.mode == HMA_NIGHT;
      s_d.stat[OBJ_FROST] = s_q.mode == HMA_FROST;
      s_d.pres = s_q.motion_cfg ? s_q.mot : s_q.mode == HMA_EXT;

      // One object is sent per cycle, lowest index first; new changes win over the clear.
      for (int i = 3; i >= 0; i--) begin
         if (s_q.pend[i]) begin
            idx = 2'(i);
         end
      end
      if (s_q.pend != 4'h0 && s_q.tx_en) begin
         s_d.txv = 1'b1;
         s_d.txo = idx;
         s_d.txval = s_q.stat[idx];
         sent[idx] = 1'b1;
      end
      s_d.pend = s_q.tx_en ? s_q.pend & ~sent : 4'h0;
      s_d.pend = s_d.pend | (s_d.stat ^ s_q.stat);
      if (s_q.init) begin
         s_d.pend = s_d.pend | s_q.stat;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.motion_cfg <= MOTION_RST;
         s_q.tx_en <= TXEN_RST;
         s_q.rd_en <= RDEN_RST;
         s_q.init <= 1'b1;
         s_q.extlen <= EXTLEN_RST;
         s_q.base <= MODE_RST;
         s_q.mode <= MODE_RST;
         s_q.stat <= STAT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = s_q.awrdy;
   assign s_axi_wready = s_q.wrdy;
   assign s_axi_bvalid = s_q.bv;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arrdy;
   assign s_axi_rvalid = s_q.rv;
   assign s_axi_rdata = s_q.rdat;
   assign s_axi_rresp = s_q.rresp;
   assign tx_valid = s_q.txv;
   assign tx_obj = s_q.txo;
   assign tx_val = s_q.txval;
   assign status_obj = s_q.stat;
   assign presence_obj = s_q.pres;
   assign op_mode = s_q.mode;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_forced_comfort: assert property (s_q.frc == FRC_COMFORT |=> s_q.mode == HMA_COMFORT)
      else $error("forced comfort not applied");
   a_forced_standby: assert property (s_q.frc == FRC_STANDBY |=> s_q.mode == HMA_STANDBY)
      else $error("forced standby not applied");
   a_window_frost: assert property (no_force && s_q.win |=> s_q.mode == HMA_FROST)
      else $error("open window did not select frost");
   a_motion_comfort: assert property (no_force && !s_q.win && s_q.motion_cfg && s_q.mot |=> s_q.mode == HMA_COMFORT)
      else $error("motion did not select comfort");
   a_co_night: assert property (wr_chg && s_q.wdat[7:0] == CO_NIGHT |=> s_q.base == HMA_NIGHT)
      else $error("change-over 03 not mapped to night");
   a_co_zero: assert property (wr_chg && s_q.wdat[7:0] == CO_NONE |=> $stable(s_q.base))
      else $error("change-over 00 altered the mode");
   a_btn_reset: assert property (wr_chg || wr_frc |=> !s_q.btn)
      else $error("presence button not reset by mode object");
   a_btn_extend: assert property (no_force && !s_q.win && !s_q.motion_cfg && s_q.btn && s_q.base == HMA_NIGHT
      && s_q.extlen != 16'h0000 |=> s_q.mode == HMA_EXT)
      else $error("button in night did not extend comfort");
   a_pres_ext: assert property (!s_q.motion_cfg |=> s_q.pres == ($past(s_q.mode) == HMA_EXT))
      else $error("presence object does not track extension");
   a_expire_drop: assert property (ext.expired && !wr_pres |=> !s_q.btn ##1 s_q.mode != HMA_EXT)
      else $error("expired extension still active");
   a_stat_onehot: assert property (##1 $onehot(s_q.stat))
      else $error("status objects not one-hot");
   a_init_queue: assert property (s_q.init && s_q.tx_en |=> s_q.pend != 4'h0)
      else $error("refresh of current mode not queued");
   a_tx_gated: assert property (s_q.txv |-> $past(s_q.tx_en))
      else $error("object sent without transmit permission");

   c_extension: cover property (s_q.mode != HMA_EXT ##1 s_q.mode == HMA_EXT);
   c_forced: cover property (s_q.frc == FRC_COMFORT ##1 s_q.mode == HMA_COMFORT);
   c_window: cover property (s_q.win ##1 s_q.mode == HMA_FROST);
   c_send: cover property (s_q.txv && s_q.txval);
endmodule : hma_mode_arbiter

// [verilog/hma_pkg.sv]
// Package of constants and types for the operating mode arbiter.
package hma_pkg;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {HMA_COMFORT, HMA_STANDBY, HMA_NIGHT, HMA_FROST, HMA_EXT} hma_mode_e;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CHG = 8'h04;
   localparam logic [7:0] ADDR_FRC = 8'h08;
   localparam logic [7:0] ADDR_WIN = 8'h0C;
   localparam logic [7:0] ADDR_PRES = 8'h10;
   localparam logic [7:0] ADDR_EXTLEN = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h18;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_MOTION_BIT = 0;
   localparam int CTRL_TXEN_BIT = 1;
   localparam int CTRL_INIT_BIT = 2;
   localparam int CTRL_RDEN_BIT = 3;
   localparam int STAT_OBJ_LSB = 4;
   localparam int STAT_PRES_BIT = 8;
   localparam int STAT_RUN_BIT = 9;
   localparam logic MOTION_RST = 1'h0;
   localparam logic TXEN_RST = 1'h1;
   localparam logic RDEN_RST = 1'h1;
   localparam logic [15:0] EXTLEN_RST = 16'h003C;
   localparam hma_mode_e MODE_RST = HMA_STANDBY;
   localparam logic [3:0] STAT_RST = 4'h2;

   // ---------------------------------------------------------------
   // Object codes and status object indices
   // ---------------------------------------------------------------
   localparam logic [7:0] CO_NONE = 8'h00;
   localparam logic [7:0] CO_COMFORT = 8'h01;
   localparam logic [7:0] CO_STANDBY = 8'h02;
   localparam logic [7:0] CO_NIGHT = 8'h03;
   localparam logic [7:0] CO_FROST = 8'h04;
   localparam logic [7:0] FRC_COMFORT = 8'h01;
   localparam logic [7:0] FRC_STANDBY = 8'h02;
   localparam int OBJ_COMFORT = 0;
   localparam int OBJ_STANDBY = 1;
   localparam int OBJ_NIGHT = 2;
   localparam int OBJ_FROST = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int EXT_TICK_MS = 1000;
   localparam int EXT_TICK_CYC = EXT_TICK_MS * 1000000 / CLK_PERIOD_NS;
endpackage : hma_pkg

// [verilog/hma_ext_if.sv]
// Interface between the arbiter and its comfort extension timer.
interface hma_ext_if;
   logic tick;
   logic start;
   logic abort;
   logic [15:0] len;
   logic running;
   logic expired;
   modport ctl (output tick, output start, output abort, output len, input running, input expired);
   modport tmr (input tick, input start, input abort, input len, output running, output expired);
endinterface : hma_ext_if

// [verilog/hma_ext_timer.sv]
// Comfort extension timer, counted in ticks, not retriggerable.
module hma_ext_timer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Control
   hma_ext_if.tmr ext
);
   typedef struct packed {
      logic run;
      logic [15:0] cnt;
      logic exp;
   } hma_tmr_s;

   hma_tmr_s s_q;
   hma_tmr_s s_d;

   always_comb begin
      s_d = s_q;
      s_d.exp = 1'b0;
      if (ext.abort) begin
         s_d.run = 1'b0;
      end else if (ext.start && !s_q.run && ext.len != 16'h0000) begin
         // A start while running is ignored: the extension cannot be retriggered.
         s_d.run = 1'b1;
         s_d.cnt = ext.len;
      end else if (s_q.run && ext.tick) begin
         if (s_q.cnt == 16'h0001) begin
            s_d.run = 1'b0;
            s_d.exp = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ext.running = s_q.run;
   assign ext.expired = s_q.exp;
endmodule : hma_ext_timer

// [tb/hma_bus_node.sv]
// Bus node model that listens to the object telegrams sent by the arbiter.
module hma_bus_node (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Telegrams
   input wire logic tx_valid,
   input wire logic [1:0] tx_obj,
   input wire logic tx_val
);
   timeunit 1ns;
   timeprecision 100ps;
   int n_q;
   logic [1:0] on_q;
   // The arbiter sends with no back-pressure, so a pulse is counted exactly once.
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         n_q <= 0;
         on_q <= 2'h3;
      end else if (tx_valid === 1'b1) begin
         n_q <= n_q + 1;
         if (tx_val === 1'b1) on_q <= tx_obj;
      end
   end
endmodule : hma_bus_node

// [tb/tb.sv]
// Self-checking testbench of the operating mode arbiter.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import hma_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, tx_obj;
   logic [31:0] s_axi_rdata, rdv;
   logic tx_valid, tx_val, presence_obj;
   logic [3:0] status_obj;
   logic [2:0] op_mode;
   logic [1:0] resp;
   int failures = 0;
   int samples_checked = 0;
   always #2 mclk = ~mclk;
   // A short tick keeps the extension of 60 ticks at 240 cycles.
   hma_mode_arbiter #(.TICK_CYC(4)) i_dut (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .tx_valid, .tx_obj, .tx_val, .status_obj, .presence_obj, .op_mode);
   hma_bus_node i_node (.mclk, .rstn, .tx_valid, .tx_obj, .tx_val);
   // ---------------------------------------------------------------
   // Bus cycles and comparisons
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Only the watchdog ends a wait that never sees the response.
      do begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      resp = s_axi_rresp;
      rdv = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd
   // The extension reports through the comfort object.
   task automatic cm(input hma_mode_e m);
      chk(32'(op_mode), 32'(m));
      chk(32'(status_obj), (m == HMA_EXT) ? 32'h1 : 32'h1 << m);
   endtask : cm
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      repeat (4) @(posedge mclk);
      chk(i_node.n_q, 1);
      chk(32'(i_node.on_q), 32'(OBJ_STANDBY));
      cm(HMA_STANDBY);
      rd(ADDR_STAT);
      chk(rdv, 32'h21);
   endtask : t_reset
   task automatic t_chg;
      int n;
      for (int i = 1; i <= 4; i++) begin
         n = i_node.n_q;
         wr(ADDR_CHG, i);
         cm(hma_mode_e'(i - 1));
         chk(i_node.n_q, n + 2);
         chk(32'(i_node.on_q), i - 1);
      end
      n = i_node.n_q;
      wr(ADDR_CHG, 32'h0);
      cm(HMA_FROST);
      chk(i_node.n_q, n);
   endtask : t_chg
   task automatic t_win;
      wr(ADDR_CHG, 32'h3);
      wr(ADDR_WIN, 32'h1);
      cm(HMA_FROST);
      wr(ADDR_CHG, 32'h2);
      cm(HMA_FROST);
      wr(ADDR_WIN, 32'h0);
      cm(HMA_STANDBY);
      wr(ADDR_WIN, 32'h1);
      wr(ADDR_FRC, 32'h1);
      cm(HMA_COMFORT);
      wr(ADDR_FRC, 32'h2);
      cm(HMA_STANDBY);
      wr(ADDR_FRC, 32'h0);
      cm(HMA_FROST);
      wr(ADDR_WIN, 32'h0);
      cm(HMA_STANDBY);
   endtask : t_win
   task automatic t_btn;
      wr(ADDR_CHG, 32'h3);
      wr(ADDR_PRES, 32'h1);
      cm(HMA_EXT);
      chk(32'(presence_obj), 32'h1);
      repeat (100) @(posedge mclk);
      chk(32'(presence_obj), 32'h1);
      repeat (300) @(posedge mclk);
      chk(32'(presence_obj), 32'h0);
      cm(HMA_NIGHT);
      wr(ADDR_PRES, 32'h1);
      cm(HMA_EXT);
      wr(ADDR_CHG, 32'h4);
      cm(HMA_FROST);
      chk(32'(presence_obj), 32'h0);
      wr(ADDR_CHG, 32'h2);
      wr(ADDR_PRES, 32'h1);
      cm(HMA_COMFORT);
      wr(ADDR_PRES, 32'h0);
      // A zero extension length leaves night mode in place.
      wr(ADDR_EXTLEN, 32'h0);
      wr(ADDR_CHG, 32'h3);
      wr(ADDR_PRES, 32'h1);
      cm(HMA_NIGHT);
      chk(32'(presence_obj), 32'h0);
      wr(ADDR_PRES, 32'h0);
      wr(ADDR_EXTLEN, 32'(EXTLEN_RST));
      rd(ADDR_EXTLEN);
      chk(rdv, 32'(EXTLEN_RST));
   endtask : t_btn
   task automatic t_mot;
      wr(ADDR_CTRL, 32'h0B);
      wr(ADDR_CHG, 32'h3);
      wr(ADDR_PRES, 32'h1);
      cm(HMA_COMFORT);
      chk(32'(presence_obj), 32'h1);
      wr(ADDR_CHG, 32'h4);
      cm(HMA_COMFORT);
      wr(ADDR_PRES, 32'h0);
      cm(HMA_FROST);
      chk(32'(presence_obj), 32'h0);
      wr(ADDR_CTRL, 32'h0A);
   endtask : t_mot
   task automatic t_cfg;
      int n;
      n = i_node.n_q;
      wr(ADDR_CTRL, 32'h08);
      wr(ADDR_CHG, 32'h1);
      chk(i_node.n_q, n);
      cm(HMA_COMFORT);
      wr(ADDR_CTRL, 32'h06);
      chk(i_node.n_q, n + 1);
      chk(32'(i_node.on_q), 32'(OBJ_COMFORT));
      rd(ADDR_STAT);
      chk(rdv, 32'h0);
      wr(ADDR_CTRL, 32'h0A);
      rd(ADDR_STAT);
      chk(rdv, 32'h10);
      rd(8'h1C);
      chk(32'(resp), 32'(RESP_SLVERR));
      chk(rdv, 32'h0);
      wr(8'h1C, 32'h1);
      chk(32'(resp), 32'(RESP_SLVERR));
      cm(HMA_COMFORT);
   endtask : t_cfg
   // A reset in mid-run must bring back standby and send its refresh again.
   task automatic t_rerun;
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
   endtask : t_rerun
   task automatic end_of_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_chg();
      t_win();
      t_btn();
      t_mot();
      t_cfg();
      t_rerun();
      end_of_test();
   end
   // The run needs some 1,000 cycles; twenty times that means a hang.
   initial begin
      #80000;
      failures++;
      end_of_test();
   end
endmodule : tb
